// *** verif/tb_top.sv ***
// Testbench: register, sleep, hibernate and watchdog scenarios
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module tb_top;
	logic clock_in, nrst_in, cyc, we, cfg, pin_n, ack, drst, wake, vec, clk_en, mosc, wosc, hold, pud, ibg, to_n, pd_n;
	logic rc, slp, clr, global_irq_enable, hit;
	logic [11:0] adr;
	logic [31:0] wdat, rdat;
	logic [5:0] en, flg;
	logic [4:0] off;
	logic [7:0] q, e;
	int mismatches = 0;
	int cmp_count = 0;
	int n;
	wspc_top #(.WDT_BASE_TICKS(8)) wspc_top_i (.clock_in(clock_in), .nrst_in(nrst_in), .wb_cyc_in(cyc),
		.wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1), .wb_dat_in(wdat), .wb_dat_out(rdat),
		.wb_ack_out(ack), .watchdog_config_enable_in(cfg), .wdt_rc_osc_in(rc), .master_reset_pin_n_in(pin_n),
		.sleep_instr_in(slp), .watchdog_clear_instr_in(clr), .global_irq_enable_in(global_irq_enable), .irq_enable_in(en),
		.irq_flag_in(flg), .device_reset_out(drst), .wake_out(wake), .wake_to_vector_out(vec),
		.cpu_clk_en_out(clk_en), .main_osc_en_out(mosc), .wdt_osc_en_out(wosc), .io_hold_out(hold),
		.pullup_disable_out(pud), .input_buffer_gate_out(ibg), .timeout_flag_n_out(to_n),
		.powerdown_flag_n_out(pd_n), .temp_sensor_off_out(off[1]), .references_off_out(off[4]),
		.comparator_off_out(off[2]), .converter_off_out(off[0]), .level_shift_off_out(off[3]));
	wspc_core_model wspc_core_model_i (.clock_in(clock_in), .rc_out(rc), .sleep_out(slp), .clear_out(clr),
		.gie_out(global_irq_enable), .en_out(en), .flag_out(flg));
	// 10 MHz clock
	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end
	// Verdict and end of run
	task conclude;
		if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Classic Wishbone cycle held until ack, then one idle cycle
	task wb(input logic w, input logic [11:0] a, input logic [7:0] d);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clock_in);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n == 20) begin
			mismatches++;
			conclude;
		end
		q = rdat[7:0];
		cyc <= 1'b0;
		@(posedge clock_in);
	endtask
	// Bounded wait for a wake (w high) or a reset pulse
	task waitev(input logic w, input int lim);
		n = 0;
		do begin
			@(posedge clock_in);
			n++;
			hit = (w ? wake : drst) === 1'b1;
		end while (!hit && n < lim);
	endtask
	task expect_ev(input logic w, input int lim);
		waitev(w, lim);
		if (!hit) begin
			mismatches++;
			conclude;
		end
	endtask
	// Main sequence
	initial begin
		{nrst_in, cyc, we, cfg, adr, wdat} = '0;
		pin_n = 1'b1;
		repeat (6) @(posedge clock_in);
		nrst_in <= 1'b1;
		@(posedge clock_in);
		wb(0, 12'h23c, 8'h00);
		`CHK({q, off}, {8'h3f, 5'h1f})
		wb(0, 12'h20c, 8'h00);
		`CHK(q[1:0], 2'h3)
		wb(0, 12'h000, 8'h00);
		`CHK(q, 8'h00)
		for (int i = 0; i < 8; i++) begin
			e = 8'h01 << i;
			wb(1, 12'h23c, e);
			wb(0, 12'h23c, 8'h00);
			`CHK({q, off}, {e & 8'hbf, e[5:4], e[2:0]})
		end
		wb(1, 12'h23c, 8'h08);
		// Pending enabled interrupt at sleep entry, every source
		for (int i = 0; i < 6; i++) begin
			wspc_core_model_i.irq(6'h01 << i, 6'h01 << i, i[0]);
			wspc_core_model_i.exec(1, 0);
			@(posedge clock_in);
			`CHK({clk_en, hold, mosc, pd_n, to_n}, 5'h09)
			expect_ev(1, 10);
			`CHK({clk_en, vec}, {1'b1, i[0]})
			wspc_core_model_i.irq(0, 0, 0);
			@(posedge clock_in);
		end
		wspc_core_model_i.irq(0, 6'h3f, 1);
		wspc_core_model_i.exec(1, 0);
		waitev(1, 30);
		`CHK(hit, 1'b0)
		wspc_core_model_i.irq(6'h3f, 6'h3f, 1);
		expect_ev(1, 10);
		wspc_core_model_i.irq(0, 0, 0);
		// Hibernate: watchdog forced off and no watchdog wake
		cfg <= 1'b1;
		wb(1, 12'h23c, 8'h88);
		wspc_core_model_i.exec(1, 0);
		@(posedge clock_in);
		`CHK({pud, ibg, wosc}, 3'b110)
		waitev(1, 300);
		`CHK(hit, 1'b0)
		wspc_core_model_i.irq(6'h01, 6'h01, 0);
		expect_ev(1, 10);
		wspc_core_model_i.irq(0, 0, 0);
		wb(1, 12'h23c, 8'h08);
		// Watchdog wakes from sleep, then resets in run
		wspc_core_model_i.exec(1, 0);
		expect_ev(1, 300);
		`CHK({to_n, drst}, 2'b00)
		wspc_core_model_i.exec(0, 1);
		expect_ev(0, 300);
		@(posedge clock_in);
		`CHK(to_n, 1'b0)
		for (int i = 0; i < 5; i++) begin
			wspc_core_model_i.exec(0, 1);
			waitev(0, 40);
			`CHK(hit, 1'b0)
		end
		// Prescale by 2 and by 128
		wb(1, 12'h204, 8'h09);
		wspc_core_model_i.exec(0, 1);
		waitev(0, 400);
		`CHK(n > 150 && n < 175, 1'b1)
		wb(1, 12'h204, 8'h0f);
		wspc_core_model_i.exec(0, 1);
		waitev(0, 12000);
		`CHK(n > 10200 && n < 10300, 1'b1)
		wb(1, 12'h204, 8'h00);
		// Reset pin during sleep resets the device
		cfg <= 1'b0;
		wspc_core_model_i.exec(1, 0);
		pin_n <= 1'b0;
		expect_ev(0, 10);
		@(posedge clock_in);
		`CHK({clk_en, wake}, 2'b10)
		pin_n <= 1'b1;
		repeat (6) @(posedge clock_in);
		waitev(0, 300);
		`CHK({hit, wosc}, 2'b00)
		conclude;
	end
endmodule

// *** verif/wspc_asserts.sv ***
// Checker: port-level properties of the watchdog and power control block
`timescale 1ns/100ps
module wspc_asserts (
	input wire logic clock_in,
	input wire logic nrst_in,
	input wire logic master_reset_pin_n_in,
	input wire logic sleep_instr_in,
	input wire logic watchdog_config_enable_in,
	input wire logic global_irq_enable_in,
	input wire logic [wspc_pkg::N_WAKE_IRQ-1:0] irq_enable_in,
	input wire logic [wspc_pkg::N_WAKE_IRQ-1:0] irq_flag_in,
	input wire logic device_reset_out,
	input wire logic wake_out,
	input wire logic wake_to_vector_out,
	input wire logic cpu_clk_en_out,
	input wire logic main_osc_en_out,
	input wire logic wdt_osc_en_out,
	input wire logic io_hold_out,
	input wire logic pullup_disable_out,
	input wire logic input_buffer_gate_out,
	input wire logic timeout_flag_n_out,
	input wire logic powerdown_flag_n_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!nrst_in);
	// Sleep command taken in run, reset pin held low
	sequence s_sleep_cmd; sleep_instr_in && cpu_clk_en_out; endsequence
	sequence s_pin_low; !master_reset_pin_n_in [*4]; endsequence
	// Core, oscillator and pin state relations
	property p_sleep; s_sleep_cmd ##1 !device_reset_out |->
		!cpu_clk_en_out && io_hold_out && !powerdown_flag_n_out && timeout_flag_n_out; endproperty
	a_sleep: assert property (p_sleep) else $error("sleep entry state wrong");
	property p_osc; cpu_clk_en_out |-> main_osc_en_out; endproperty
	a_osc: assert property (p_osc) else $error("main oscillator off while running");
	property p_hold; io_hold_out != cpu_clk_en_out; endproperty
	a_hold: assert property (p_hold) else $error("pin hold disagrees with cpu clock");
	property p_wdt_cfg; wdt_osc_en_out |-> watchdog_config_enable_in; endproperty
	a_wdt_cfg: assert property (p_wdt_cfg) else $error("watchdog runs while disabled");
	property p_hib; pullup_disable_out |-> input_buffer_gate_out && !wdt_osc_en_out && io_hold_out; endproperty
	a_hib: assert property (p_hib) else $error("hibernate outputs inconsistent");
	property p_vec; wake_to_vector_out |-> wake_out; endproperty
	a_vec: assert property (p_vec) else $error("vector without wake");
	// Enabled pending interrupt wakes on the next cycle
	property p_irq_wake; !cpu_clk_en_out && (|(irq_enable_in & irq_flag_in)) |=>
		wake_out && cpu_clk_en_out && wake_to_vector_out == $past(global_irq_enable_in); endproperty
	a_irq_wake: assert property (p_irq_wake) else $error("interrupt wake missing");
	property p_pin; s_pin_low |-> device_reset_out && cpu_clk_en_out; endproperty
	a_pin: assert property (p_pin) else $error("reset pin ignored");
endmodule
bind wspc_top wspc_asserts wspc_asserts_i (.clock_in(clock_in), .nrst_in(nrst_in),
	.master_reset_pin_n_in(master_reset_pin_n_in), .sleep_instr_in(sleep_instr_in),
	.watchdog_config_enable_in(watchdog_config_enable_in), .global_irq_enable_in(global_irq_enable_in),
	.irq_enable_in(irq_enable_in), .irq_flag_in(irq_flag_in), .device_reset_out(device_reset_out),
	.wake_out(wake_out), .wake_to_vector_out(wake_to_vector_out), .cpu_clk_en_out(cpu_clk_en_out),
	.main_osc_en_out(main_osc_en_out), .wdt_osc_en_out(wdt_osc_en_out), .io_hold_out(io_hold_out),
	.pullup_disable_out(pullup_disable_out), .input_buffer_gate_out(input_buffer_gate_out),
	.timeout_flag_n_out(timeout_flag_n_out), .powerdown_flag_n_out(powerdown_flag_n_out));

// *** verif/wspc_core_model.sv ***
// Core model: instruction pulses, interrupt levels and watchdog RC oscillator
`timescale 1ns/100ps
module wspc_core_model (
	input wire logic clock_in,
	output logic rc_out,
	output logic sleep_out,
	output logic clear_out,
	output logic gie_out,
	output logic [wspc_pkg::N_WAKE_IRQ-1:0] en_out,
	output logic [wspc_pkg::N_WAKE_IRQ-1:0] flag_out
);
	// Free-running RC oscillator, ten system clocks a period
	initial begin
		{sleep_out, clear_out, gie_out, en_out, flag_out} = '0;
		rc_out = 1'b0;
		forever #500 rc_out = ~rc_out;
	end
	// One-cycle sleep or clear pulse, called just after an edge
	task exec(input logic s, input logic c);
		sleep_out <= s;
		clear_out <= c;
		@(posedge clock_in);
		sleep_out <= 1'b0;
		clear_out <= 1'b0;
	endtask
	// Interrupt enable, flag and global enable levels
	task irq(input logic [5:0] e, input logic [5:0] f, input logic g);
		en_out <= e;
		flag_out <= f;
		gie_out <= g;
	endtask
endmodule

// *** verilog/wspc_pkg.sv ***
// Package: register map, field positions, reset values and timing of the watchdog and power control block
package wspc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [9:0] PWR_CTRL_IDX = 10'h08f;
	localparam logic [9:0] OPTION_IDX = 10'h081;
	localparam logic [9:0] STATUS_IDX = 10'h083;
	localparam int WB_ADR_W = 12;

	// Power control fields
	localparam int PWR_HIB_BIT = 7;
	localparam int PWR_REF_BIT = 5;
	localparam int PWR_LS_BIT = 4;
	localparam int PWR_OSC_BIT = 3;
	localparam int PWR_CMP_BIT = 2;
	localparam int PWR_TEMP_BIT = 1;
	localparam int PWR_CONV_BIT = 0;
	localparam logic [7:0] PWR_RESET = 8'h3f;
	localparam logic [7:0] PWR_WMASK = 8'hbf;

	// Option fields: prescaler ratio select and assignment to the watchdog
	localparam int OPT_PS_LSB = 0;
	localparam int OPT_PS_W = 3;
	localparam int OPT_PSA_BIT = 3;
	localparam logic [3:0] OPT_RESET = 4'h0;

	// Status fields
	localparam int STAT_TO_BIT = 0;
	localparam int STAT_PD_BIT = 1;
	localparam int STAT_STATE_LSB = 2;
	localparam int STAT_WDT_BIT = 4;

	// Watchdog timing
	localparam int WDT_PERIOD_US = 18000;
	localparam int RC_FREQ_KHZ = 1000;
	localparam int WDT_BASE_TICKS = WDT_PERIOD_US * RC_FREQ_KHZ / 1000;

	// Wake-capable interrupt sources
	localparam int N_WAKE_IRQ = 6;
	localparam int IRQ_PUSH_BUTTON_PIN = 0;
	localparam int IRQ_PORTC = 1;
	localparam int IRQ_SERIAL = 2;
	localparam int IRQ_REFCMP = 3;
	localparam int IRQ_CONV = 4;
	localparam int IRQ_CONVTMR = 5;

	typedef enum logic [1:0] {
		WSPC_RUN,
		WSPC_SLEEP,
		WSPC_HIBERNATE
	} wspc_state_t;
endpackage

// *** verilog/wspc_top.sv ***
// Watchdog timer with sleep, hibernate and analog power control
`timescale 1ns/100ps

module wspc_top #(
	parameter int WDT_BASE_TICKS = wspc_pkg::WDT_BASE_TICKS
) (
	input wire logic clock_in,
	input wire logic nrst_in,
	// Wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [wspc_pkg::WB_ADR_W-1:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// Core and pins
	input wire logic watchdog_config_enable_in,
	input wire logic wdt_rc_osc_in,
	input wire logic master_reset_pin_n_in,
	input wire logic sleep_instr_in,
	input wire logic watchdog_clear_instr_in,
	input wire logic global_irq_enable_in,
	input wire logic [wspc_pkg::N_WAKE_IRQ-1:0] irq_enable_in,
	input wire logic [wspc_pkg::N_WAKE_IRQ-1:0] irq_flag_in,
	output logic device_reset_out,
	output logic wake_out,
	output logic wake_to_vector_out,
	output logic cpu_clk_en_out,
	output logic main_osc_en_out,
	output logic wdt_osc_en_out,
	output logic io_hold_out,
	output logic pullup_disable_out,
	output logic input_buffer_gate_out,
	output logic timeout_flag_n_out,
	output logic powerdown_flag_n_out,
	output logic temp_sensor_off_out,
	output logic references_off_out,
	output logic comparator_off_out,
	output logic converter_off_out,
	output logic level_shift_off_out
);
	localparam int CNT_W = $clog2(WDT_BASE_TICKS + 1);
	localparam int PSC_W = (1 << wspc_pkg::OPT_PS_W) - 1;

	typedef struct packed {
		wspc_pkg::wspc_state_t state;
		logic ack;
		logic [31:0] rdata;
		logic [7:0] pwr;
		logic [3:0] opt;
		logic to_n;
		logic pd_n;
		logic [CNT_W-1:0] wdt_cnt;
		logic [PSC_W-1:0] ps_cnt;
		logic rc_s1;
		logic rc_s2;
		logic rc_prev;
		logic master_reset_pin_n_s1;
		logic master_reset_pin_n_s2;
		logic rst;
		logic wake;
		logic vec;
	} wspc_regs_t;

	wspc_regs_t cur_ff;
	wspc_regs_t nxt_ff;

	logic wdt_active;
	logic rc_edge;
	logic [PSC_W-1:0] ps_limit;
	logic ps_tick;
	logic expire;
	logic irq_wake;
	logic wdt_clear;
	logic bus_req;
	logic [9:0] reg_idx;
	logic [7:0] wr_byte;

	// Watchdog enable and RC oscillator edge detection
	always_comb begin
		wdt_active = watchdog_config_enable_in && (cur_ff.state != wspc_pkg::WSPC_HIBERNATE);
		rc_edge = cur_ff.rc_s2 && !cur_ff.rc_prev;
	end

	// Prescaler ratio: 2^n when assigned to the watchdog, 1:1 otherwise
	always_comb begin
		if (cur_ff.opt[wspc_pkg::OPT_PSA_BIT]) begin
			ps_limit = PSC_W'((1 << cur_ff.opt[wspc_pkg::OPT_PS_LSB +: wspc_pkg::OPT_PS_W]) - 1);
		end else begin
			ps_limit = '0;
		end
		ps_tick = wdt_active && rc_edge && (cur_ff.ps_cnt >= ps_limit);
		expire = ps_tick && (cur_ff.wdt_cnt == CNT_W'(WDT_BASE_TICKS - 1));
	end

	// Wake sources gated by their own enables only; global enable ignored here
	always_comb begin
		irq_wake = |(irq_enable_in & irq_flag_in);
		wdt_clear = watchdog_clear_instr_in || sleep_instr_in;
		bus_req = wb_cyc_in && wb_stb_in && !cur_ff.ack;
		reg_idx = wb_adr_in[wspc_pkg::WB_ADR_W-1:2];
		wr_byte = wb_dat_in[7:0];
	end

	// Next-state logic for the whole block
	always_comb begin
		nxt_ff = cur_ff;
		nxt_ff.rst = 1'b0;
		nxt_ff.wake = 1'b0;
		nxt_ff.vec = 1'b0;

		// Two-stage synchronisers for pins from other domains
		nxt_ff.rc_s1 = wdt_rc_osc_in;
		nxt_ff.rc_s2 = cur_ff.rc_s1;
		nxt_ff.rc_prev = cur_ff.rc_s2;
		nxt_ff.master_reset_pin_n_s1 = master_reset_pin_n_in;
		nxt_ff.master_reset_pin_n_s2 = cur_ff.master_reset_pin_n_s1;

		// Watchdog counter and prescaler advance on RC edges
		if (wdt_active && rc_edge) begin
			if (ps_tick) begin
				nxt_ff.ps_cnt = '0;
				nxt_ff.wdt_cnt = expire ? '0 : cur_ff.wdt_cnt + CNT_W'(1);
			end else begin
				nxt_ff.ps_cnt = cur_ff.ps_cnt + PSC_W'(1);
			end
		end
		if (!wdt_active) begin
			nxt_ff.wdt_cnt = '0;
			nxt_ff.ps_cnt = '0;
		end

		// Watchdog expiry clears the time-out flag
		if (expire) begin
			nxt_ff.to_n = 1'b0;
		end

		case (cur_ff.state)
			wspc_pkg::WSPC_RUN: begin
				if (expire) begin
					nxt_ff.rst = 1'b1;
				end else if (sleep_instr_in) begin
					// Sleep entry; next instruction already prefetched by the core
					nxt_ff.wdt_cnt = '0;
					nxt_ff.ps_cnt = '0;
					nxt_ff.pd_n = 1'b0;
					nxt_ff.to_n = 1'b1;
					if (cur_ff.pwr[wspc_pkg::PWR_HIB_BIT]) begin
						nxt_ff.state = wspc_pkg::WSPC_HIBERNATE;
					end else begin
						nxt_ff.state = wspc_pkg::WSPC_SLEEP;
					end
				end else if (wdt_clear) begin
					nxt_ff.wdt_cnt = '0;
					nxt_ff.ps_cnt = '0;
					nxt_ff.to_n = 1'b1;
					nxt_ff.pd_n = 1'b1;
				end
			end
			wspc_pkg::WSPC_SLEEP, wspc_pkg::WSPC_HIBERNATE: begin
				if (irq_wake || expire) begin
					// Interrupt or watchdog wake resumes at the prefetched instruction
					nxt_ff.state = wspc_pkg::WSPC_RUN;
					nxt_ff.wake = 1'b1;
					nxt_ff.vec = irq_wake && global_irq_enable_in;
					nxt_ff.wdt_cnt = '0;
					nxt_ff.ps_cnt = '0;
				end
			end
			default: begin
				nxt_ff.state = wspc_pkg::WSPC_RUN;
			end
		endcase

		// External reset pin resets the device from any state back to run, with no wake pulse
		if (!cur_ff.master_reset_pin_n_s2) begin
			nxt_ff.state = wspc_pkg::WSPC_RUN;
			nxt_ff.rst = 1'b1;
			nxt_ff.wake = 1'b0;
			nxt_ff.vec = 1'b0;
			nxt_ff.wdt_cnt = '0;
			nxt_ff.ps_cnt = '0;
		end

		// Wishbone slave: one-cycle ack, zero for unmapped reads
		nxt_ff.ack = bus_req;
		if (bus_req) begin
			nxt_ff.rdata = '0;
			case (reg_idx)
				wspc_pkg::PWR_CTRL_IDX: begin
					nxt_ff.rdata[7:0] = cur_ff.pwr;
					if (wb_we_in && wb_sel_in[0]) begin
						nxt_ff.pwr = wr_byte & wspc_pkg::PWR_WMASK;
					end
				end
				wspc_pkg::OPTION_IDX: begin
					nxt_ff.rdata[3:0] = cur_ff.opt;
					if (wb_we_in && wb_sel_in[0]) begin
						nxt_ff.opt = wr_byte[3:0];
					end
				end
				wspc_pkg::STATUS_IDX: begin
					nxt_ff.rdata[wspc_pkg::STAT_TO_BIT] = cur_ff.to_n;
					nxt_ff.rdata[wspc_pkg::STAT_PD_BIT] = cur_ff.pd_n;
					nxt_ff.rdata[wspc_pkg::STAT_STATE_LSB +: 2] = cur_ff.state;
					nxt_ff.rdata[wspc_pkg::STAT_WDT_BIT] = wdt_active;
				end
				default: begin
					nxt_ff.rdata = '0;
				end
			endcase
		end
	end

	// State register; power-on reset sets both status flags
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cur_ff <= '0;
			cur_ff.state <= wspc_pkg::WSPC_RUN;
			cur_ff.pwr <= wspc_pkg::PWR_RESET;
			cur_ff.opt <= wspc_pkg::OPT_RESET;
			cur_ff.to_n <= 1'b1;
			cur_ff.pd_n <= 1'b1;
			cur_ff.master_reset_pin_n_s1 <= 1'b1;
			cur_ff.master_reset_pin_n_s2 <= 1'b1;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	// Bus outputs
	assign wb_ack_out = cur_ff.ack;
	assign wb_dat_out = cur_ff.rdata;

	// Reset and wake signalling to the core; no drive on the reset pin
	assign device_reset_out = cur_ff.rst;
	assign wake_out = cur_ff.wake;
	assign wake_to_vector_out = cur_ff.vec;

	// Clock and power gating
	assign cpu_clk_en_out = (cur_ff.state == wspc_pkg::WSPC_RUN);
	assign main_osc_en_out = (cur_ff.state == wspc_pkg::WSPC_RUN) || !cur_ff.pwr[wspc_pkg::PWR_OSC_BIT];
	assign wdt_osc_en_out = wdt_active;
	assign io_hold_out = (cur_ff.state != wspc_pkg::WSPC_RUN);
	assign pullup_disable_out = (cur_ff.state == wspc_pkg::WSPC_HIBERNATE);
	assign input_buffer_gate_out = (cur_ff.state == wspc_pkg::WSPC_HIBERNATE);

	// Status flags
	assign timeout_flag_n_out = cur_ff.to_n;
	assign powerdown_flag_n_out = cur_ff.pd_n;

	// Analog module power switches
	assign temp_sensor_off_out = cur_ff.pwr[wspc_pkg::PWR_TEMP_BIT];
	assign references_off_out = cur_ff.pwr[wspc_pkg::PWR_REF_BIT];
	assign comparator_off_out = cur_ff.pwr[wspc_pkg::PWR_CMP_BIT];
	assign converter_off_out = cur_ff.pwr[wspc_pkg::PWR_CONV_BIT];
	assign level_shift_off_out = cur_ff.pwr[wspc_pkg::PWR_LS_BIT];
endmodule
